// File: core/opp_pkg.sv
// Purpose: constants for the one-time-programmable memory access port
// Assumes: core clock at 20 MHz
// Notes:   select codes, timing and reset values shared by the port logic
package opp_pkg;
    localparam int CLK_HZ          = 20_000_000;
    localparam int WRITE_STROBE_A_TIME_US    = 100;
    // a least time: clock taken in whole MHz, rounded down, never below one cycle
    localparam int WRITE_STROBE_A_CYCLES_RAW = (WRITE_STROBE_A_TIME_US * (CLK_HZ / 1_000_000));
    localparam int WRITE_STROBE_A_CYCLES     =
        (WRITE_STROBE_A_CYCLES_RAW < 1) ? 1 : WRITE_STROBE_A_CYCLES_RAW;
    localparam int CODE_BYTES      = 32768;
    localparam int ADDR_W          = 15;
    localparam int LOW_ADDR_W      = 8;
    localparam int HIGH_ADDR_W     = 7;
    localparam int LOCK_W          = 2;
    localparam int VER_BYTES       = 256;
    localparam int SYNC_STAGES     = 3;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [1:0] LOCK_RESET  = 2'h0;
    localparam logic [6:0] HIGH_RESET  = 7'h00;
    localparam logic [12:0] CNT_RESET  = 13'h0000;

    typedef enum logic [1:0] {
        OPP_SEL_RSVD    = 2'b00,
        OPP_SEL_VERSION = 2'b01,
        OPP_SEL_LOCK    = 2'b10,
        OPP_SEL_CODE    = 2'b11
    } opp_sel_e;

    typedef enum logic [1:0] {
        OPP_ST_IDLE  = 2'b00,
        OPP_ST_BURN  = 2'b01,
        OPP_ST_WAIT  = 2'b10
    } opp_state_e;
endpackage : opp_pkg

// File: core/opp_port.sv
// Purpose: slave access port for the code store in programming mode
// Assumes: all programmer pins are asynchronous to core_clk
// Notes:   data pins split into in, out and output enable
`timescale 1ns/1ps
`default_nettype none
module opp_port #(
    parameter int WRITE_STROBE_A_CYC  = opp_pkg::WRITE_STROBE_A_CYCLES,
    parameter logic [7:0] VERSION_ID = 8'hA5  // arbitrary value
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       write_strobe_a_mode,
    input  wire logic       access_select_low,
    input  wire logic       access_select_high,
    input  wire logic       write_strobe_a_read_strobe_n,
    input  wire logic       write_strobe_a_addr_latch_strobe,
    input  wire logic       write_strobe_a_n,
    input  wire logic       ext_access_write_strobe_a_voltage,
    input  wire logic [7:0] addr_pins,
    input  wire logic [7:0] data_in,
    output var  logic [7:0] data_out,
    output var  logic       data_oe,
    output var  logic       busy,
    output var  logic [1:0] lock_level
);
    localparam int NS = opp_pkg::SYNC_STAGES;

    // three-stage synchronisers; stage 0 feeds only stage 1
    logic [NS-1:0] ale_sync_reg, rd_sync_reg, wr_sync_reg, vpp_sync_reg;
    logic [NS-1:0] ale_sync_next, rd_sync_next, wr_sync_next, vpp_sync_next;
    logic [NS-1:0] sl_sync_reg, sh_sync_reg, pm_sync_reg;
    logic [NS-1:0] sl_sync_next, sh_sync_next, pm_sync_next;
    logic [7:0]    a_s1_reg, a_s2_reg, a_s3_reg, d_s1_reg, d_s2_reg, d_s3_reg;

    always_comb begin
        ale_sync_next = {ale_sync_reg[NS-2:0], write_strobe_a_addr_latch_strobe};
        rd_sync_next  = {rd_sync_reg[NS-2:0], write_strobe_a_read_strobe_n};
        wr_sync_next  = {wr_sync_reg[NS-2:0], write_strobe_a_n};
        vpp_sync_next = {vpp_sync_reg[NS-2:0], ext_access_write_strobe_a_voltage};
        sl_sync_next  = {sl_sync_reg[NS-2:0], access_select_low};
        sh_sync_next  = {sh_sync_reg[NS-2:0], access_select_high};
        pm_sync_next  = {pm_sync_reg[NS-2:0], write_strobe_a_mode};
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ale_sync_reg <= '0;
            rd_sync_reg  <= '1;
            wr_sync_reg  <= '1;
            vpp_sync_reg <= '0;
            sl_sync_reg  <= '0;
            sh_sync_reg  <= '0;
            pm_sync_reg  <= '0;
            a_s1_reg     <= 8'h00;
            a_s2_reg     <= 8'h00;
            a_s3_reg     <= 8'h00;
            d_s1_reg     <= 8'h00;
            d_s2_reg     <= 8'h00;
            d_s3_reg     <= 8'h00;
        end else begin
            ale_sync_reg <= ale_sync_next;
            rd_sync_reg  <= rd_sync_next;
            wr_sync_reg  <= wr_sync_next;
            vpp_sync_reg <= vpp_sync_next;
            sl_sync_reg  <= sl_sync_next;
            sh_sync_reg  <= sh_sync_next;
            pm_sync_reg  <= pm_sync_next;
            a_s1_reg     <= addr_pins;
            a_s2_reg     <= a_s1_reg;
            a_s3_reg     <= a_s2_reg;
            d_s1_reg     <= data_in;
            d_s2_reg     <= d_s1_reg;
            d_s3_reg     <= d_s2_reg;
        end
    end

    // a change counts once stages one and two agree
    function automatic logic agreed(input logic [NS-1:0] s, input logic prev);
        agreed = (s[1] == s[2]) ? s[1] : prev;
    endfunction : agreed

    logic ale_reg, rd_n_reg, wr_n_reg, vpp_reg, pm_reg;
    logic ale_next, rd_n_next, wr_n_next, vpp_next, pm_next;
    logic [1:0] sel_reg, sel_next;
    logic ale_fall, wr_fall;

    always_comb begin
        ale_next  = agreed(ale_sync_reg, ale_reg);
        rd_n_next = agreed(rd_sync_reg, rd_n_reg);
        wr_n_next = agreed(wr_sync_reg, wr_n_reg);
        vpp_next  = agreed(vpp_sync_reg, vpp_reg);
        pm_next   = agreed(pm_sync_reg, pm_reg);
        sel_next  = {agreed(sh_sync_reg, sel_reg[1]),
                     agreed(sl_sync_reg, sel_reg[0])};
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ale_reg  <= 1'b0;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            vpp_reg  <= 1'b0;
            pm_reg   <= 1'b0;
            sel_reg  <= 2'b00;
        end else begin
            ale_reg  <= ale_next;
            rd_n_reg <= rd_n_next;
            wr_n_reg <= wr_n_next;
            vpp_reg  <= vpp_next;
            pm_reg   <= pm_next;
            sel_reg  <= sel_next;
        end
    end

    assign ale_fall = ale_reg & ~ale_next;
    assign wr_fall  = wr_n_reg & ~wr_n_next;

    logic [6:0] high_reg, high_next;
    always_comb begin
        high_next = high_reg;
        if (pm_reg && ale_fall)
            high_next = a_s3_reg[6:0];
    end

    // full address from latched high and live low byte
    logic [14:0] addr;
    assign addr = {high_reg, a_s3_reg};

    // code store, erased to all ones
    logic [7:0] mem [opp_pkg::CODE_BYTES];
    logic [1:0] lock_reg, lock_next;
    logic [12:0] cnt_reg, cnt_next;
    opp_pkg::opp_state_e st_reg, st_next;
    logic        mem_we;

    // program cycle timer; only external strobes start it
    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        lock_next = lock_reg;
        mem_we    = 1'b0;
        unique case (st_reg)
            opp_pkg::OPP_ST_IDLE: begin
                if (pm_reg && wr_fall && vpp_reg) begin
                    // write decode; lock bits only ever set
                    if (sel_reg == opp_pkg::OPP_SEL_CODE) begin
                        mem_we = 1'b1;
                        st_next = opp_pkg::OPP_ST_BURN;
                        cnt_next = 13'(WRITE_STROBE_A_CYC - 1);
                    end else if (sel_reg == opp_pkg::OPP_SEL_LOCK) begin
                        lock_next = lock_reg | d_s3_reg[1:0];
                        st_next = opp_pkg::OPP_ST_BURN;
                        cnt_next = 13'(WRITE_STROBE_A_CYC - 1);
                    end
                end
            end
            opp_pkg::OPP_ST_BURN: begin
                if (cnt_reg == opp_pkg::CNT_RESET)
                    st_next = opp_pkg::OPP_ST_WAIT;
                else
                    cnt_next = cnt_reg - 13'h0001;
            end
            opp_pkg::OPP_ST_WAIT: begin
                if (wr_n_reg)
                    st_next = opp_pkg::OPP_ST_IDLE;
            end
            default: st_next = opp_pkg::OPP_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg   <= opp_pkg::OPP_ST_IDLE;
            cnt_reg  <= opp_pkg::CNT_RESET;
            lock_reg <= opp_pkg::LOCK_RESET;
            high_reg <= opp_pkg::HIGH_RESET;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            lock_reg <= lock_next;
            high_reg <= high_next;
        end
    end

    // one-time cells: a byte can only clear bits, never set them
    always_ff @(posedge core_clk) begin
        if (mem_we)
            mem[addr] <= mem[addr] & d_s3_reg;
    end

    initial begin
        for (int i = 0; i < opp_pkg::CODE_BYTES; i++)
            mem[i] = opp_pkg::ERASED_BYTE;
    end

    // read data by select; drive only in read selects
    logic [7:0] rdata, dout_next;
    logic       oe_next;
    always_comb begin
        rdata = 8'h00;
        unique case (opp_pkg::opp_sel_e'(sel_reg))
            opp_pkg::OPP_SEL_CODE:    rdata = mem[addr];
            opp_pkg::OPP_SEL_LOCK:    rdata = {6'h00, lock_reg};
            opp_pkg::OPP_SEL_VERSION: rdata = (a_s3_reg == 8'h00) ?
                                              VERSION_ID : 8'hFF;
            opp_pkg::OPP_SEL_RSVD:    rdata = 8'h00;
        endcase
        // data lines turn around for reads
        oe_next   = pm_reg && !rd_n_reg && wr_n_reg &&
                    (sel_reg != opp_pkg::OPP_SEL_RSVD);
        dout_next = oe_next ? rdata : 8'h00;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data_out   <= 8'h00;
            data_oe    <= 1'b0;
            busy       <= 1'b0;
            lock_level <= opp_pkg::LOCK_RESET;
        end else begin
            data_out   <= dout_next;
            data_oe    <= oe_next;
            busy       <= (st_next == opp_pkg::OPP_ST_BURN);
            lock_level <= lock_next;
        end
    end

    a_oe_reserved: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (sel_reg == 2'b00) |=> !data_oe)
        else $error("drove in reserved");
    a_burn_length: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(busy) |-> busy[*8])
        else $error("burn ended early");
    a_high_latch: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (pm_reg && ale_fall) |=> high_reg == $past(a_s3_reg[6:0]))
        else $error("high address not latched");
    a_read_drive: assert property (
        @(posedge core_clk) disable iff (!nrst)
        rd_n_reg |=> !data_oe)
        else $error("drove without read");
    // lock level seen outside never loses a bit
    a_lock_sticky: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ($past(lock_level) & ~lock_level) == 2'b00)
        else $error("lock cleared");
    a_write_burn: assert property (
        @(posedge core_clk) disable iff (!nrst)
        mem_we |=> busy)
        else $error("write without burn");
    a_slave_only: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (st_reg == opp_pkg::OPP_ST_IDLE && !pm_reg) |=> !busy)
        else $error("burn without mode");
    a_data_quiet: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !data_oe |-> data_out == 8'h00)
        else $error("data not quiet");
    c_code_write: cover property (@(posedge core_clk) mem_we);
    c_lock_write: cover property (@(posedge core_clk)
        lock_next != lock_reg);
    c_code_read: cover property (@(posedge core_clk)
        data_oe && sel_reg == 2'b11);
endmodule : opp_port
`default_nettype wire

// File: verif/opp_programmer.sv
// Purpose: programmer model driving the programming-mode pins
// Assumes: pins change just after a rising core_clk edge
// Notes:   each pin is held several cycles to pass the input filters
`timescale 1ns/1ps
`default_nettype none
module opp_programmer #(
    parameter int HOLD     = 6,
    parameter int BUSY_MAX = 64
) (
    input  wire logic       core_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       busy,
    output var  logic       write_strobe_a_mode,
    output var  logic       access_select_low,
    output var  logic       access_select_high,
    output var  logic       write_strobe_a_read_strobe_n,
    output var  logic       write_strobe_a_addr_latch_strobe,
    output var  logic       write_strobe_a_n,
    output var  logic       ext_access_write_strobe_a_voltage,
    output var  logic [7:0] addr_pins,
    output wire logic [7:0] data_in
);
    logic [7:0] drv_val;
    logic       drv_en;
    // bus level
    // a released bus shows the inverse so stale data never matches
    assign data_in = data_oe ? data_out : (drv_en ? drv_val : ~drv_val);
    // mode held
    // write_strobe_a_mode stands in for entry sequence and reset pin held high
    initial begin
        {write_strobe_a_mode, access_select_low, access_select_high} = 3'h0;
        {write_strobe_a_addr_latch_strobe, ext_access_write_strobe_a_voltage, drv_en} = 3'h0;
        {write_strobe_a_read_strobe_n, write_strobe_a_n} = 2'h3;
        addr_pins = 8'h00;
        drv_val = 8'h00;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask : step
    task automatic addr_phase(input logic [1:0] sel, input logic [14:0] a);
        write_strobe_a_mode <= 1'b1;
        {access_select_high, access_select_low} <= sel;
        step(HOLD);
        write_strobe_a_addr_latch_strobe <= 1'b1;
        addr_pins <= {1'b0, a[14:8]};
        step(HOLD);
        write_strobe_a_addr_latch_strobe <= 1'b0;
        step(HOLD);
        addr_pins <= a[7:0];
    endtask : addr_phase
    // strobe held
    // the strobe stays low until the burn ends, so no early next write
    task automatic write_byte(input logic [1:0] sel, input logic [14:0] a,
                              input logic [7:0] d, input logic vpp,
                              output int bcnt);
        bcnt = 0;
        addr_phase(sel, a);
        drv_val <= d;
        drv_en <= 1'b1;
        ext_access_write_strobe_a_voltage <= vpp;
        step(HOLD);
        write_strobe_a_n <= 1'b0;
        for (int n = 0; n < BUSY_MAX; n++) begin
            step(1);
            if (busy === 1'b1) bcnt++;
            else if (bcnt > 0) break;
        end
        write_strobe_a_n <= 1'b1;
        step(HOLD);
        drv_en <= 1'b0;
        ext_access_write_strobe_a_voltage <= 1'b0;
    endtask : write_byte
    task automatic read_byte(input logic [1:0] sel, input logic [14:0] a,
                             output logic [7:0] d, output int oe);
        d = 8'hXX;
        oe = 0;
        addr_phase(sel, a);
        step(HOLD);
        write_strobe_a_read_strobe_n <= 1'b0;
        repeat (10) begin
            step(1);
            if (data_oe === 1'b1) begin
                oe++;
                d = data_out;
            end
        end
        write_strobe_a_read_strobe_n <= 1'b1;
        step(HOLD + 2);
    endtask : read_byte
endmodule : opp_programmer
`default_nettype wire

// File: verif/otp_programming_mode_port_test.sv
// Purpose: self-checking bench for the programming-mode access port
// Assumes: burn length shortened to WRITE_STROBE_A cycles
// Notes:   random addresses and data come from a bench lfsr
`timescale 1ns/1ps
`default_nettype none
module otp_programming_mode_port_test;
    localparam int WRITE_STROBE_A = 16;
    localparam logic [7:0] VER = 8'h5A;  // arbitrary value
    localparam logic [1:0] CODE = opp_pkg::OPP_SEL_CODE;
    localparam logic [1:0] LOCK = opp_pkg::OPP_SEL_LOCK;
    localparam logic [1:0] VERS = opp_pkg::OPP_SEL_VERSION;
    logic core_clk, nrst, pm, sl, sh, rd_n, ale, wr_n, vpp, oe, busy;
    logic [7:0] addr, din, dout;
    logic [1:0] lock_level, lock_exp;
    logic [7:0] mem [logic [14:0]];
    logic [31:0] lfsr;
    int error_cnt, check_count;
    opp_port #(.WRITE_STROBE_A_CYC(WRITE_STROBE_A), .VERSION_ID(VER)) u_opp_port (
        .core_clk(core_clk), .nrst(nrst), .write_strobe_a_mode(pm),
        .access_select_low(sl), .access_select_high(sh),
        .write_strobe_a_read_strobe_n(rd_n), .write_strobe_a_addr_latch_strobe(ale),
        .write_strobe_a_n(wr_n), .ext_access_write_strobe_a_voltage(vpp),
        .addr_pins(addr), .data_in(din), .data_out(dout), .data_oe(oe),
        .busy(busy), .lock_level(lock_level));
    opp_programmer #(.BUSY_MAX(WRITE_STROBE_A + 40)) u_opp_programmer (
        .core_clk(core_clk), .data_out(dout), .data_oe(oe), .busy(busy),
        .write_strobe_a_mode(pm), .access_select_low(sl), .access_select_high(sh),
        .write_strobe_a_read_strobe_n(rd_n), .write_strobe_a_addr_latch_strobe(ale),
        .write_strobe_a_n(wr_n), .ext_access_write_strobe_a_voltage(vpp),
        .addr_pins(addr), .data_in(din));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] code_exp(input logic [14:0] a);
        return mem.exists(a) ? mem[a] : opp_pkg::ERASED_BYTE;
    endfunction : code_exp
    task automatic check(input string nm, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic rd_chk(input logic [1:0] sel, input logic [14:0] a,
                          input logic [7:0] e, m);
        logic [7:0] d;
        int n;
        u_opp_programmer.read_byte(sel, a, d, n);
        check("read_drive", 16'(n > 0), 16'(m != 0));
        check("read_data", 16'(d & m), 16'(e & m));
        check("oe_after", 16'(oe), 16'h0000);
    endtask : rd_chk
    task automatic wr(input logic [1:0] sel, input logic [14:0] a,
                      input logic [7:0] v, input logic p, input int eb);
        int bc;
        u_opp_programmer.write_byte(sel, a, v, p, bc);
        check("burn_cycles", 16'(bc), 16'(eb));
    endtask : wr
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        finish_test();
    end
    initial begin : main
        logic [14:0] a;
        nrst = 1'b0;
        lfsr = 32'h3034;
        lock_exp = 2'h0;
        repeat (4) @(posedge core_clk);
        check("reset_out", 16'({oe, busy, lock_level}), 16'h0000);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        $display("test reset done");
        for (int i = 0; i < 14; i++) begin
            lfsr = lfsr_next(lfsr);
            a = (i == 0 || i == 2) ? 15'h7FFF :
                (i == 1) ? 15'h0000 : lfsr[14:0];
            wr(CODE, a, lfsr[23:16], 1'b1, WRITE_STROBE_A);
            mem[a] = code_exp(a) & lfsr[23:16];
            rd_chk(CODE, a, code_exp(a), 8'hFF);
            rd_chk(CODE, a ^ 15'h4000, code_exp(a ^ 15'h4000), 8'hFF);
        end
        $display("test code store done");
        wr(CODE, 15'h0000, 8'h00, 1'b0, 0);
        wr(VERS, 15'h0000, 8'h00, 1'b1, 0);
        rd_chk(CODE, 15'h0000, code_exp(15'h0000), 8'hFF);
        rd_chk(VERS, 15'h0000, VER, 8'hFF);
        rd_chk(VERS, 15'h0001, 8'hFF, 8'hFF);
        rd_chk(opp_pkg::OPP_SEL_RSVD, 15'h0000, 8'h00, 8'h00);
        $display("test refusals done");
        for (int k = 0; k < 2; k++) begin
            wr(LOCK, 15'h0000, k ? 8'hFE : 8'h01, 1'b1, WRITE_STROBE_A);
            lock_exp = lock_exp | (k ? 2'h2 : 2'h1);
            check("lock_level", 16'(lock_level), 16'(lock_exp));
            rd_chk(LOCK, 15'h0000, {6'h00, lock_exp}, 8'h03);
        end
        $display("test lock bits done");
        finish_test();
    end
endmodule : otp_programming_mode_port_test
`default_nettype wire
